/* src/orsq_pkg.sv */
// Package for the origin-return sequencer: encodings, defaults and timing.
// Assumes a 125 MHz system clock; all other rates derive from it.
package orsq_pkg;
  localparam int          ORSQ_CLK_HZ        = 125000000;
  localparam int          ORSQ_MS_PER_S      = 1000;
  localparam int          ORSQ_CYC_PER_MS    = ORSQ_CLK_HZ / ORSQ_MS_PER_S;
  // Mode, direction and mark selection codes.
  localparam logic [1:0]  ORSQ_MODE_TWO      = 2'h0;
  localparam logic [1:0]  ORSQ_MODE_THREE    = 2'h1;
  localparam logic [1:0]  ORSQ_MODE_ONE      = 2'h2;
  localparam logic [1:0]  ORSQ_MODE_PUSH     = 2'h3;
  localparam logic        ORSQ_DIR_NEG       = 1'h0;
  localparam logic        ORSQ_DIR_POS       = 1'h1;
  localparam logic [1:0]  ORSQ_MARK_OFF      = 2'h0;
  localparam logic [1:0]  ORSQ_MARK_PHASE    = 2'h1;
  localparam logic [1:0]  ORSQ_MARK_ZERO     = 2'h2;
  // Setting limits.
  localparam logic [31:0] ORSQ_ACC_MAX       = 32'h3b9aca00;
  localparam logic [21:0] ORSQ_SPEED_MAX     = 22'h3d0900;
  localparam logic [21:0] ORSQ_LAST_MAX      = 22'h002710;
  localparam logic [7:0]  ORSQ_FILT_MAX      = 8'hc8;
  localparam logic [22:0] ORSQ_STEPS_MAX     = 23'h7fffff;
  localparam logic [9:0]  ORSQ_CUR_MAX       = 10'h3e8;
  // Defaults after reset.
  localparam logic [1:0]  ORSQ_MODE_RST      = ORSQ_MODE_THREE;
  localparam logic [31:0] ORSQ_ACC_RST       = 32'h000f4240;
  localparam logic [21:0] ORSQ_START_RST     = 22'h0001f4;
  localparam logic [21:0] ORSQ_RUN_RST       = 22'h0003e8;
  localparam logic [21:0] ORSQ_LASTSPD_RST   = 22'h0001f4;
  localparam logic [7:0]  ORSQ_FILT_RST      = 8'h01;
  localparam logic [15:0] ORSQ_PUSHT_RST     = 16'h00c8;
  // Phase accumulator width for step generation.
  localparam int          ORSQ_ACC_W         = 27;
  localparam logic [26:0] ORSQ_PHASE_WRAP    = 27'h773593f; // ORSQ_CLK_HZ - 1
  typedef enum logic [8:0] {
    ORSQ_IDLE    = 9'h001,
    ORSQ_SEEK    = 9'h002,
    ORSQ_LEAVE   = 9'h004,
    ORSQ_FIND    = 9'h008,
    ORSQ_BACK    = 9'h010,
    ORSQ_PUSHB   = 9'h020,
    ORSQ_PRESS   = 9'h040,
    ORSQ_QUAL    = 9'h080,
    ORSQ_OFFSET  = 9'h100
  } orsq_state_type;
endpackage

/* src/orsq_step_gen.sv */
// Step-rate generator: emits one-cycle step enables at a commanded rate.
// Assumes the caller supplies a rate in Hz and a clock at the package system clock rate.
`timescale 1ns/1ps
module orsq_step_gen
  import orsq_pkg::*;
#(
  parameter int RATE_W = 22
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_run,
  input  wire logic [RATE_W-1:0] i_rate_hz,
  output logic                   o_step
);
  initial begin
    if (RATE_W > ORSQ_ACC_W) $error("orsq_step_gen: RATE_W too wide");
  end

  logic [ORSQ_ACC_W-1:0] phase_reg;
  logic [ORSQ_ACC_W-1:0] phase_next;
  logic [ORSQ_ACC_W:0]   phase_sum;
  logic                  step_reg;

  // Fractional phase add; a wrap past the clock rate is one step.
  assign phase_sum  = {1'b0, phase_reg} + {{(ORSQ_ACC_W-RATE_W+1){1'b0}}, i_rate_hz};
  assign phase_next = (phase_sum > {1'b0, ORSQ_PHASE_WRAP}) ?
                      ORSQ_ACC_W'(phase_sum - {1'b0, ORSQ_PHASE_WRAP} - 1'b1) :
                      phase_sum[ORSQ_ACC_W-1:0];

  // The accumulator clears when stopped so each move starts in phase.
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_run) begin
      phase_reg <= '0;
      step_reg  <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      step_reg  <= (phase_sum > {1'b0, ORSQ_PHASE_WRAP});
    end
  end

  assign o_step = step_reg;
endmodule // orsq_step_gen

/* src/orsq_sequencer.sv */
// Origin-return sequencer: runs homing in four modes, presets position.
// Assumes sensor and request pins are asynchronous; settings are static during a run.
//
// Summary of operation
// RULE1: Mode setting picks two, three, one sensor or push; default three-sensor.
// RULE2: Start direction negative when 0, positive when 1; default positive.
// RULE3: Acceleration setting 1 to 1e9, default 1,000,000, shapes speed ramping.
// RULE4: Starting and operating speeds 1 to 4 MHz; defaults 500 and 1000 Hz.
// RULE5: Last speed 1 to 10,000 Hz, default 500, for final positioning.
// RULE6: Command filter time constant 1 to 200 ms smooths the commanded speed.
// RULE7: Two-sensor mode moves backward steps after leaving the limit.
// RULE8: Single-sensor mode travels extra steps after leaving the origin sensor.
// RULE9: Push mode limits motor current to a 0.1 percent rate up to 1000.
// RULE10: Push mode backs off given steps after first hitting the stop.
// RULE11: Push complete once torque limit persists for the pushing time in ms.
// RULE12: Push mode retreats given steps from the stop and takes that as origin.
// RULE13: On completion the position is loaded with the preset value.
// RULE14: Absolute position valid stays low while origin return runs.
// RULE15: After return, move by the signed offset and take that point as origin.
// RULE16: Aperture sensor must qualify the origin when its enable is 1.
// RULE17: Mark setting 1 uses phase origin pulse, 2 encoder zero mark.
// RULE18: Host must set resolution to a multiple of 50 for phase pulse use.
// RULE19: Host asserts request only while ready, releases after ready drops.
// RULE20: On accept drop ready outputs, raise motion active, then start moving.
// RULE21: On completion raise done and ready outputs, drop motion and busy.
// RULE22: Three-sensor reverses at limit, leaves it, stops on origin rising edge.
// RULE23: Two-sensor reverses at limit, pulls out, then runs backward steps.
// RULE24: Single-sensor stops on origin rise, leaves at last speed, no further reversal.
// RULE25: Push mode uses pressing against the stop as the reversal event.
// RULE26: All sensor and request inputs are synchronised and edge detected; the code reads limits, aperture and torque as levels only.
// RULE27: A new request during a return is ignored; ready stays low.
`timescale 1ns/1ps
module orsq_sequencer
  import orsq_pkg::*;
#(
  parameter int PUSH_MS_CYC = ORSQ_CYC_PER_MS
) (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST,
  input  wire logic        I_SEEK_REQ,
  input  wire logic        I_ORIGIN_SENSOR,
  input  wire logic        I_LIMIT_POS,
  input  wire logic        I_LIMIT_NEG,
  input  wire logic        I_APERTURE_SENSOR,
  input  wire logic        I_PHASE_ORIGIN_PULSE,
  input  wire logic        I_ENCODER_ZERO_MARK,
  input  wire logic        I_TORQUE_LIMIT_REACHED,
  input  wire logic [1:0]  I_MODE,
  input  wire logic        I_START_DIR,
  input  wire logic [31:0] I_ACCEL,
  input  wire logic [21:0] I_START_SPEED,
  input  wire logic [21:0] I_RUN_SPEED,
  input  wire logic [21:0] I_LAST_SPEED,
  input  wire logic [7:0]  I_FILTER_MS,
  input  wire logic [9:0]  I_PUSH_CURRENT,
  input  wire logic [22:0] I_BACK_STEPS_TWO,
  input  wire logic [22:0] I_EXTRA_STEPS_ONE,
  input  wire logic [22:0] I_PUSH_FIRST_STEPS,
  input  wire logic [15:0] I_PUSH_TIME_MS,
  input  wire logic [22:0] I_PUSH_BACK_STEPS,
  input  wire logic [31:0] I_PRESET_POS,
  input  wire logic [31:0] I_POS_OFFSET,
  input  wire logic        I_APERTURE_EN,
  input  wire logic [1:0]  I_MARK_SEL,
  output logic             O_PULSE_INPUT_READY,
  output logic             O_READY,
  output logic             O_DIRECT_COMMAND_READY,
  output logic             O_MOTION_ACTIVE,
  output logic             O_OPERATION_BUSY,
  output logic             O_ORIGIN_DONE,
  output logic             O_ABSOLUTE_POSITION_VALID,
  output logic             O_STEP,
  output logic             O_DIR,
  output logic [9:0]       O_CURRENT_LIMIT,
  output logic [31:0]      O_POSITION
);
  initial begin
    if (PUSH_MS_CYC < 1) $error("orsq_sequencer: PUSH_MS_CYC must be positive");
  end

  localparam int NSYNC = 8;

  // Two-flop synchronisers, then an edge stage read by the sequencer.
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] last_reg;
  assign pin_raw = {I_SEEK_REQ, I_ORIGIN_SENSOR, I_LIMIT_POS, I_LIMIT_NEG,
                    I_APERTURE_SENSOR, I_PHASE_ORIGIN_PULSE, I_ENCODER_ZERO_MARK,
                    I_TORQUE_LIMIT_REACHED};
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      last_reg  <= '0;
    end else begin
      sync1_reg <= pin_raw; // RULE26
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
    end
  end

  wire req_rise    = sync2_reg[7] & ~last_reg[7];
  wire org_lvl     = sync2_reg[6];
  wire org_rise    = sync2_reg[6] & ~last_reg[6]; // RULE26
  wire org_fall    = ~sync2_reg[6] & last_reg[6];
  wire lim_pos     = sync2_reg[5];
  wire lim_neg     = sync2_reg[4];
  wire aperture    = sync2_reg[3];
  wire mark_rise   = (I_MARK_SEL == ORSQ_MARK_PHASE) ? (sync2_reg[2] & ~last_reg[2]) :
                     (I_MARK_SEL == ORSQ_MARK_ZERO)  ? (sync2_reg[1] & ~last_reg[1]) : 1'b0;
  wire torque      = sync2_reg[0];

  // Qualification of the final origin point by aperture and mark signals.
  wire need_qual   = I_APERTURE_EN | (I_MARK_SEL != ORSQ_MARK_OFF);
  wire qual_ok     = (~I_APERTURE_EN | aperture) &                     // RULE16
                     ((I_MARK_SEL == ORSQ_MARK_OFF) | mark_rise);      // RULE17

  orsq_state_type state_reg, state_next;
  logic           dir_reg, dir_next;
  logic [22:0]    cnt_reg, cnt_next;
  logic [31:0]    ofs_left_reg, ofs_left_next;
  logic [31:0]    pos_reg, pos_next;
  logic           done_reg, done_next;
  logic           valid_reg, valid_next;
  logic [31:0]    ptime_reg, ptime_next;
  logic [21:0]    target_hz;
  logic [21:0]    speed_reg;
  logic [31:0]    ramp_reg;
  logic [31:0]    ms_reg;
  logic           pressed_reg, pressed_next;

  wire busy       = (state_reg != ORSQ_IDLE);
  wire moving     = busy;
  wire at_limit   = dir_reg ? lim_pos : lim_neg;
  wire push_hit   = (ptime_reg >= 32'(I_PUSH_TIME_MS) * 32'(PUSH_MS_CYC)); // RULE11
  wire step_en;
  wire ofs_neg    = I_POS_OFFSET[31];
  wire [31:0] ofs_mag = ofs_neg ? (~I_POS_OFFSET + 32'h1) : I_POS_OFFSET;

  // Target speed by phase: seek at operating speed (starting speed in two-sensor mode), find at operating speed, pull-outs at last speed.
  always_comb begin
    target_hz = I_START_SPEED;
    case (state_reg)
      ORSQ_SEEK:   target_hz = (I_MODE == ORSQ_MODE_TWO) ? I_START_SPEED : I_RUN_SPEED; // RULE4
      ORSQ_FIND:   target_hz = I_RUN_SPEED;
      ORSQ_LEAVE:  target_hz = I_LAST_SPEED; // RULE5
      ORSQ_QUAL:   target_hz = I_LAST_SPEED;
      default:     target_hz = I_START_SPEED;
    endcase
  end

  // Filter tick every ms; speed slews toward target by accel/filter per tick.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST || !moving) begin
      ms_reg    <= '0;
      ramp_reg  <= '0;
      speed_reg <= I_START_SPEED;
    end else if (ms_reg >= 32'(ORSQ_CYC_PER_MS - 1)) begin
      ms_reg <= '0;
      // Ramp step in Hz per ms: accel (0.001 kHz/s) equals 1 mHz/ms units.
      ramp_reg <= I_ACCEL / (32'(I_FILTER_MS) * 32'(ORSQ_MS_PER_S)) + 32'h1; // RULE3 RULE6
      if (speed_reg < target_hz)
        speed_reg <= ((target_hz - speed_reg) > ramp_reg[21:0]) ?
                     speed_reg + ramp_reg[21:0] : target_hz;
      else
        speed_reg <= ((speed_reg - target_hz) > ramp_reg[21:0]) ?
                     speed_reg - ramp_reg[21:0] : target_hz;
    end else begin
      ms_reg <= ms_reg + 32'h1;
    end
  end

  orsq_step_gen #(.RATE_W(22)) u_step (
    .i_clk     (I_CLK_SYS),
    .i_rst     (I_RST),
    .i_run     (moving),
    .i_rate_hz (speed_reg),
    .o_step    (step_en)
  );

  // Main sequencer.
  always_comb begin
    state_next    = state_reg;
    dir_next      = dir_reg;
    cnt_next      = cnt_reg;
    ofs_left_next = ofs_left_reg;
    pos_next      = pos_reg;
    done_next     = done_reg;
    valid_next    = valid_reg;
    ptime_next    = '0;
    pressed_next  = pressed_reg;
    if (step_en && busy)
      pos_next = dir_reg ? pos_reg + 32'h1 : pos_reg - 32'h1;
    case (state_reg)
      ORSQ_IDLE: begin
        if (req_rise) begin // RULE19 RULE20
          state_next   = ORSQ_SEEK;
          dir_next     = (I_START_DIR == ORSQ_DIR_POS); // RULE2
          done_next    = 1'b0;
          valid_next   = 1'b0; // RULE14
          pressed_next = 1'b0;
        end
      end
      ORSQ_SEEK: begin // RULE1
        if (I_MODE == ORSQ_MODE_PUSH) begin
          ptime_next = torque ? ptime_reg + 32'h1 : '0;
          if (push_hit) begin // RULE25
            dir_next   = ~dir_reg;
            cnt_next   = pressed_reg ? I_PUSH_BACK_STEPS : I_PUSH_FIRST_STEPS;
            state_next = pressed_reg ? ORSQ_BACK : ORSQ_PUSHB; // RULE10 RULE12
          end
        end else if (I_MODE == ORSQ_MODE_ONE) begin
          if (org_rise) state_next = ORSQ_LEAVE; // RULE24
        end else if (I_MODE == ORSQ_MODE_THREE && org_rise) begin
          state_next = need_qual ? ORSQ_QUAL : ORSQ_OFFSET; // RULE22
          cnt_next   = '0;
        end else if (at_limit) begin
          dir_next   = ~dir_reg; // RULE22 RULE23
          state_next = ORSQ_LEAVE;
        end
      end
      ORSQ_LEAVE: begin
        if (I_MODE == ORSQ_MODE_ONE) begin
          if (org_fall) begin
            cnt_next   = I_EXTRA_STEPS_ONE; // RULE8
            state_next = ORSQ_BACK;
          end
        end else if (!lim_pos && !lim_neg) begin
          if (I_MODE == ORSQ_MODE_TWO) begin
            cnt_next   = I_BACK_STEPS_TWO; // RULE7 RULE23
            state_next = ORSQ_BACK;
          end else
            state_next = ORSQ_FIND;
        end
      end
      ORSQ_FIND: begin
        if (org_rise) state_next = need_qual ? ORSQ_QUAL : ORSQ_OFFSET; // RULE22
      end
      ORSQ_PUSHB, ORSQ_BACK: begin
        if (cnt_reg == '0) begin
          if (state_reg == ORSQ_PUSHB) begin
            dir_next     = ~dir_reg;
            pressed_next = 1'b1;
            state_next   = ORSQ_SEEK;
          end else
            state_next = need_qual ? ORSQ_QUAL : ORSQ_OFFSET;
        end else if (step_en)
          cnt_next = cnt_reg - 23'h1;
      end
      ORSQ_QUAL: begin
        if (qual_ok && (org_lvl || I_MODE == ORSQ_MODE_PUSH)) state_next = ORSQ_OFFSET;
      end
      ORSQ_OFFSET: begin
        if (ofs_left_reg == '0) begin
          state_next = ORSQ_IDLE;
          pos_next   = I_PRESET_POS; // RULE13
          done_next  = 1'b1; // RULE21
          valid_next = 1'b1;
        end else if (step_en)
          ofs_left_next = ofs_left_reg - 32'h1;
      end
      default: state_next = ORSQ_IDLE;
    endcase
    // Offset run direction and length latch on entry to the offset phase.
    if (state_next == ORSQ_OFFSET && state_reg != ORSQ_OFFSET) begin
      ofs_left_next = ofs_mag; // RULE15
      if (ofs_mag != '0) dir_next = ~ofs_neg; // A zero offset keeps the direction.
    end
  end

  // State registers; a request while busy has no path and is ignored.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      state_reg    <= ORSQ_IDLE;
      dir_reg      <= ORSQ_DIR_POS;
      cnt_reg      <= '0;
      ofs_left_reg <= '0;
      pos_reg      <= '0;
      done_reg     <= 1'b0;
      valid_reg    <= 1'b0;
      ptime_reg    <= '0;
      pressed_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next; // RULE27
      dir_reg      <= dir_next;
      cnt_reg      <= cnt_next;
      ofs_left_reg <= ofs_left_next;
      pos_reg      <= pos_next;
      done_reg     <= done_next;
      valid_reg    <= valid_next;
      ptime_reg    <= ptime_next;
      pressed_reg  <= pressed_next;
    end
  end

  // Ready, motion and busy outputs follow the busy state directly.
  assign O_PULSE_INPUT_READY       = ~busy; // RULE20 RULE21
  assign O_READY                   = ~busy; // RULE27
  assign O_DIRECT_COMMAND_READY    = ~busy;
  assign O_MOTION_ACTIVE           = busy;
  assign O_OPERATION_BUSY          = busy;
  assign O_ORIGIN_DONE             = done_reg;
  assign O_ABSOLUTE_POSITION_VALID = valid_reg & ~busy; // RULE14
  assign O_STEP                    = step_en & busy;
  assign O_DIR                     = dir_reg;
  assign O_CURRENT_LIMIT           = (busy && I_MODE == ORSQ_MODE_PUSH) ?
                                     ((I_PUSH_CURRENT > ORSQ_CUR_MAX) ? ORSQ_CUR_MAX :
                                      I_PUSH_CURRENT) : ORSQ_CUR_MAX; // RULE9
  assign O_POSITION                = pos_reg;
endmodule // orsq_sequencer

/* test/orsq_sequencer_asserts.sv */
// Checker for the origin-return sequencer, bound to its top module.
// Assumes orsq_pkg is compiled first and that the block runs on one clock.
`timescale 1ns/1ps
module orsq_sequencer_asserts
  import orsq_pkg::*;
#(
  parameter int PUSH_MS_CYC = 10
) (
  input wire logic        I_CLK_SYS,
  input wire logic        I_RST,
  input wire logic        I_SEEK_REQ,
  input wire logic [1:0]  I_MODE,
  input wire logic        I_START_DIR,
  input wire logic [9:0]  I_PUSH_CURRENT,
  input wire logic [31:0] I_PRESET_POS,
  input wire logic [31:0] I_POS_OFFSET,
  input wire logic        O_PULSE_INPUT_READY,
  input wire logic        O_READY,
  input wire logic        O_DIRECT_COMMAND_READY,
  input wire logic        O_MOTION_ACTIVE,
  input wire logic        O_OPERATION_BUSY,
  input wire logic        O_ORIGIN_DONE,
  input wire logic        O_ABSOLUTE_POSITION_VALID,
  input wire logic        O_STEP,
  input wire logic        O_DIR,
  input wire logic [9:0]  O_CURRENT_LIMIT,
  input wire logic [31:0] O_POSITION
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  // Remembers that the running return has issued its first step.
  logic stepped_reg;
  logic stepped_next;
  assign stepped_next = O_MOTION_ACTIVE & (stepped_reg | O_STEP);
  always_ff @(posedge I_CLK_SYS) begin
    stepped_reg <= I_RST ? 1'b0 : stepped_next;
  end
  a_accept_answer: assert property ($rose(I_SEEK_REQ) && O_READY |->
    ##[1:5] (!O_READY && O_MOTION_ACTIVE && O_OPERATION_BUSY))
    else $error("request not answered by a busy state");
  a_ready_group: assert property (O_READY == !O_OPERATION_BUSY &&
    O_PULSE_INPUT_READY == O_READY && O_DIRECT_COMMAND_READY == O_READY &&
    O_MOTION_ACTIVE == O_OPERATION_BUSY) else $error("ready outputs disagree with busy");
  a_valid_off_run: assert property (O_OPERATION_BUSY |-> !O_ABSOLUTE_POSITION_VALID)
    else $error("position valid while returning");
  a_done_finish: assert property ($rose(O_ORIGIN_DONE) |-> O_READY &&
    !O_OPERATION_BUSY && O_ABSOLUTE_POSITION_VALID && O_POSITION == I_PRESET_POS)
    else $error("completion outputs or preset wrong");
  a_busy_ends_done: assert property ($fell(O_OPERATION_BUSY) |-> O_ORIGIN_DONE)
    else $error("busy ended without done");
  a_done_stands: assert property (O_ORIGIN_DONE && !O_OPERATION_BUSY |=>
    O_ORIGIN_DONE || O_OPERATION_BUSY) else $error("done dropped while idle");
  a_push_current: assert property (O_OPERATION_BUSY && I_MODE == ORSQ_MODE_PUSH |->
    O_CURRENT_LIMIT == I_PUSH_CURRENT) else $error("push current not applied");
  a_idle_current: assert property (!O_OPERATION_BUSY |-> O_CURRENT_LIMIT == ORSQ_CUR_MAX)
    else $error("idle current not full");
  a_start_dir: assert property (O_STEP && !stepped_reg |-> O_DIR == I_START_DIR)
    else $error("first step in wrong direction");
  a_one_no_reverse: assert property (O_OPERATION_BUSY && stepped_reg &&
    I_MODE == ORSQ_MODE_ONE && I_POS_OFFSET == 32'h0 |-> O_DIR == I_START_DIR)
    else $error("single-sensor run reversed");
  a_idle_no_step: assert property (!O_OPERATION_BUSY |-> !O_STEP)
    else $error("step while idle");
  // Main scenarios that the bench is expected to reach.
  c_push_done: cover property ($rose(O_ORIGIN_DONE) && I_MODE == ORSQ_MODE_PUSH);
  c_one_done: cover property ($rose(O_ORIGIN_DONE) && I_MODE == ORSQ_MODE_ONE);
  c_two_done: cover property ($rose(O_ORIGIN_DONE) && I_MODE == ORSQ_MODE_TWO);
  c_busy_req: cover property ($rose(I_SEEK_REQ) && O_OPERATION_BUSY);
endmodule // orsq_sequencer_asserts

bind orsq_sequencer orsq_sequencer_asserts #(.PUSH_MS_CYC(PUSH_MS_CYC)) u_asserts (
  .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_SEEK_REQ(I_SEEK_REQ), .I_MODE(I_MODE),
  .I_START_DIR(I_START_DIR), .I_PUSH_CURRENT(I_PUSH_CURRENT), .I_PRESET_POS(I_PRESET_POS),
  .I_POS_OFFSET(I_POS_OFFSET), .O_PULSE_INPUT_READY(O_PULSE_INPUT_READY),
  .O_READY(O_READY), .O_DIRECT_COMMAND_READY(O_DIRECT_COMMAND_READY),
  .O_MOTION_ACTIVE(O_MOTION_ACTIVE), .O_OPERATION_BUSY(O_OPERATION_BUSY),
  .O_ORIGIN_DONE(O_ORIGIN_DONE), .O_ABSOLUTE_POSITION_VALID(O_ABSOLUTE_POSITION_VALID),
  .O_STEP(O_STEP), .O_DIR(O_DIR), .O_CURRENT_LIMIT(O_CURRENT_LIMIT), .O_POSITION(O_POSITION));

/* test/orsq_mech_model.sv */
// Mechanism model: a carriage moved by step pulses, with sensors and a stopper.
// Assumes one step pulse per step and direction high for positive motion.
`timescale 1ns/1ps
module orsq_mech_model
  import orsq_pkg::*;
#(
  parameter int LIMIT_AT  = 24,
  parameter int ORIGIN_AT = -2,
  parameter int STOP_AT   = 20
) (
  input  wire logic          i_clk,
  input  wire logic          i_step,
  input  wire logic          i_dir,
  output logic               o_origin_sensor,
  output logic               o_limit_pos,
  output logic               o_limit_neg,
  output logic               o_aperture_sensor,
  output logic               o_phase_origin_pulse,
  output logic               o_encoder_zero_mark,
  output logic               o_torque_limit_reached,
  output logic signed [31:0] o_pos
);
  logic [3:0]         tick_reg = 4'h0;
  logic signed [31:0] pos_reg  = 32'sh0;
  // A step into the stopper is lost, so pressing never moves the carriage.
  always_ff @(posedge i_clk) begin
    tick_reg <= tick_reg + 4'h1;
    if (i_step && !(i_dir && pos_reg == STOP_AT)) begin
      pos_reg <= i_dir ? pos_reg + 32'sh1 : pos_reg - 32'sh1;
    end
  end
  // Sensors decode the carriage position; one step wide origin and aperture.
  assign o_pos = pos_reg;
  assign o_limit_pos = pos_reg >= LIMIT_AT;
  assign o_limit_neg = pos_reg <= -LIMIT_AT;
  assign o_origin_sensor = pos_reg == ORIGIN_AT;
  assign o_aperture_sensor = pos_reg == ORIGIN_AT;
  // Marks repeat every 16 clocks, well inside one step, as from a whole-cycle resolution.
  // A qualifying edge so always falls while the carriage still stands on the origin.
  assign o_phase_origin_pulse = tick_reg < 4'h4;
  assign o_encoder_zero_mark = tick_reg >= 4'hc;
  assign o_torque_limit_reached = i_dir && pos_reg == STOP_AT;
endmodule // orsq_mech_model

/* test/orsq_sequencer_tb.sv */
// Self-checking bench: runs every homing mode against the mechanism model.
// Assumes orsq_pkg, the design and the mechanism model are compiled first.
`timescale 1ns/1ps
module orsq_sequencer_tb
  import orsq_pkg::*;
;
  localparam int PUSH_CYC = 10;
  logic        clk, rst, seek_req, start_dir, ap_en;
  logic [1:0]  mode, mark_sel;
  logic [9:0]  push_cur, cur_lim;
  logic [22:0] back_two, extra_one, push_first, push_back;
  logic [15:0] push_ms;
  logic [31:0] preset, offset, pos, mech;
  logic        org, lim_p, lim_n, aper, phase, zmark, torque;
  logic        rdy_pi, rdy, rdy_dc, moving, busy, done, valid, step, dir;
  logic        done_d = 1'b0;
  int          fail_count, comparisons, e, b, k;
  logic [31:0] exp_q[$];
  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  orsq_sequencer #(.PUSH_MS_CYC(PUSH_CYC)) dut (
    .I_CLK_SYS(clk), .I_RST(rst), .I_SEEK_REQ(seek_req), .I_ORIGIN_SENSOR(org),
    .I_LIMIT_POS(lim_p), .I_LIMIT_NEG(lim_n), .I_APERTURE_SENSOR(aper),
    .I_PHASE_ORIGIN_PULSE(phase), .I_ENCODER_ZERO_MARK(zmark),
    .I_TORQUE_LIMIT_REACHED(torque), .I_MODE(mode), .I_START_DIR(start_dir),
    .I_ACCEL(ORSQ_ACC_RST), .I_START_SPEED(ORSQ_SPEED_MAX), .I_RUN_SPEED(ORSQ_SPEED_MAX),
    .I_LAST_SPEED(ORSQ_LAST_MAX), .I_FILTER_MS(ORSQ_FILT_RST), .I_PUSH_CURRENT(push_cur),
    .I_BACK_STEPS_TWO(back_two), .I_EXTRA_STEPS_ONE(extra_one),
    .I_PUSH_FIRST_STEPS(push_first), .I_PUSH_TIME_MS(push_ms),
    .I_PUSH_BACK_STEPS(push_back), .I_PRESET_POS(preset), .I_POS_OFFSET(offset),
    .I_APERTURE_EN(ap_en), .I_MARK_SEL(mark_sel), .O_PULSE_INPUT_READY(rdy_pi),
    .O_READY(rdy), .O_DIRECT_COMMAND_READY(rdy_dc), .O_MOTION_ACTIVE(moving),
    .O_OPERATION_BUSY(busy), .O_ORIGIN_DONE(done), .O_ABSOLUTE_POSITION_VALID(valid),
    .O_STEP(step), .O_DIR(dir), .O_CURRENT_LIMIT(cur_lim), .O_POSITION(pos));
  orsq_mech_model u_mech (
    .i_clk(clk), .i_step(step), .i_dir(dir), .o_origin_sensor(org), .o_limit_pos(lim_p),
    .o_limit_neg(lim_n), .o_aperture_sensor(aper), .o_phase_origin_pulse(phase),
    .o_encoder_zero_mark(zmark), .o_torque_limit_reached(torque), .o_pos(mech));
  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic close_out();
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Requests one return, notes its results, and waits for completion.
  task automatic run(input logic [1:0] m, input logic d, input int want, input bit poke);
    int n;
    @(negedge clk);
    mode = m;
    start_dir = d;
    preset = $urandom();
    exp_q.push_back(preset);
    exp_q.push_back(32'(want));
    seek_req = 1'b1;
    n = 0;
    while (rdy !== 1'b0 && n < 10) begin
      @(negedge clk);
      n++;
    end
    check("motion", 1, moving);
    check("command_ready", 0, rdy_dc);
    check("valid", 0, valid);
    check("pulse_ready", 0, rdy_pi);
    check("busy", 1, busy);
    check("current", (m == ORSQ_MODE_PUSH) ? 32'(push_cur) : 32'(ORSQ_CUR_MAX), cur_lim);
    seek_req = 1'b0;
    if (poke) begin
      repeat (40) @(negedge clk);
      seek_req = 1'b1;
      repeat (8) @(negedge clk);
      seek_req = 1'b0;
      check("ready", 0, rdy);
    end
    n = 0;
    while (done !== 1'b1 && n < 15000) begin
      @(negedge clk);
      n++;
    end
    if (n == 15000) check("done", 1, done);
    repeat (4) @(negedge clk);
  endtask
  // Watches completions and checks them against the oldest notes.
  always @(negedge clk) begin
    done_d <= done;
    if (done === 1'b1 && done_d === 1'b0) begin
      if (exp_q.size() < 2) begin
        check("queue", 2, exp_q.size());
      end else begin
        check("position", exp_q.pop_front(), pos);
        check("carriage", exp_q.pop_front(), mech);
        check("valid", 1, valid);
        check("pulse_ready", 1, rdy_pi);
      end
    end
  end
  // Cuts a hang short.
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    close_out();
  end
  // Main sequence: reset, then each mode with its own carriage target.
  initial begin
    {seek_req, ap_en, mark_sel, offset, push_first, preset} = '0;
    mode = ORSQ_MODE_RST;
    start_dir = ORSQ_DIR_POS;
    rst = 1'b1;
    fail_count = 0;
    comparisons = 0;
    void'($urandom(32'hb073a835));
    e = $urandom_range(8, 1);
    b = $urandom_range(8, 1);
    k = $urandom_range(2, 1);
    extra_one = 23'(e);
    back_two = 23'(b);
    push_back = 23'(k);
    push_cur = 10'($urandom_range(1000));
    push_ms = 16'h0003;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    check("ready", 1, rdy);
    check("done", 0, done);
    check("position", 0, pos);
    run(ORSQ_MODE_ONE, ORSQ_DIR_NEG, -3 - e, 1'b0);
    offset = 32'h00000001;
    run(ORSQ_MODE_TWO, ORSQ_DIR_NEG, -22 + b, 1'b0);
    offset = 32'h00000000;
    run(ORSQ_MODE_THREE, ORSQ_DIR_NEG, -2, 1'b1);
    ap_en = 1'b1;
    mark_sel = ORSQ_MARK_PHASE;
    run(ORSQ_MODE_THREE, ORSQ_DIR_NEG, -2, 1'b0);
    ap_en = 1'b0;
    mark_sel = ORSQ_MARK_ZERO;
    run(ORSQ_MODE_PUSH, ORSQ_DIR_POS, 20 - k, 1'b0);
    close_out();
  end
endmodule // orsq_sequencer_tb
